// ==== core/acr_pkg.sv ====
// Constants shared by the converter configuration register bank
package acr_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [3:0] ACR_ADDR_MODE     = 4'h2;
  localparam logic [3:0] ACR_ADDR_CLOCK    = 4'h3;
  localparam logic [3:0] ACR_ADDR_GAIN     = 4'h4;
  localparam logic [3:0] ACR_ADDR_RESERVED = 4'h5;
  localparam logic [3:0] ACR_ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ACR_ADDR_IRQ_MASK = 4'h9;

  // ==========================================================
  // Reset values
  localparam logic [3:0]  ACR_MODE_RST     = 4'h0;
  localparam logic [15:0] ACR_CLOCK_RST    = 16'h030e;
  localparam logic [15:0] ACR_GAIN_RST     = 16'h0000;
  localparam logic [15:0] ACR_RESERVED_RST = 16'h0000;
  localparam logic [1:0]  ACR_IRQ_RST      = 2'h0;

  // ==========================================================
  // Field positions
  localparam int ACR_MODE_FMT     = 0;
  localparam int ACR_MODE_FLOAT   = 1;
  localparam int ACR_MODE_SEL_LO  = 2;
  localparam int ACR_CLK_PWR_LO   = 0;
  localparam int ACR_CLK_OSR_LO   = 2;
  localparam int ACR_CLK_TURBO    = 5;
  localparam int ACR_CLK_EN_LO    = 8;
  localparam int ACR_GAIN0_LO     = 0;
  localparam int ACR_GAIN_CONFIG_LO     = 4;
  // Clock register bits 15:10 read only as zero
  localparam logic [15:0] ACR_CLOCK_WMASK = 16'h03ff;

  // ==========================================================
  // Encodings
  localparam logic [1:0]  ACR_SEL_LAG   = 2'h0;
  localparam logic [1:0]  ACR_SEL_OR    = 2'h1;
  localparam logic [1:0]  ACR_PWR_VLP   = 2'h0;
  localparam logic [1:0]  ACR_PWR_LP    = 2'h1;
  localparam logic [14:0] ACR_OSR_BASE  = 15'h0080;
  localparam logic [14:0] ACR_OSR_TURBO = 15'h0040;
  localparam logic [7:0]  ACR_GAIN_UNIT = 8'h01;

  // ==========================================================
  // Timing of the ready pulse
  localparam int ACR_CLK_PERIOD_NS = 40;
  localparam int ACR_PULSE_NS      = 200;
  localparam int ACR_PULSE_CYCLES_I =
    (ACR_PULSE_NS + ACR_CLK_PERIOD_NS - 1) / ACR_CLK_PERIOD_NS;
  localparam logic [7:0] ACR_PULSE_CYCLES = 8'(ACR_PULSE_CYCLES_I < 1 ? 1 : ACR_PULSE_CYCLES_I);

  // ==========================================================
  // Ready pin states
  typedef enum logic [3:0] {
    ACR_RDY_IDLE  = 4'b0001,
    ACR_RDY_HOLD  = 4'b0010,
    ACR_RDY_PULSE = 4'b0100,
    ACR_RDY_SPENT = 4'b1000
  } acr_rdy_state_t;

endpackage

// ==== core/acr_pulse_timer.sv ====
// Fixed-length cycle timer for the ready pulse
`timescale 1ns/10ps
module acr_pulse_timer
  import acr_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic start_in,
  output logic      done_out
);

  logic [7:0] count_reg;
  logic       busy_reg;

  // ==========================================================
  // Counter
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      count_reg <= 8'h00;
      busy_reg  <= 1'b0;
    end else if (start_in) begin
      count_reg <= 8'(ACR_PULSE_CYCLES - 8'h01);
      busy_reg  <= 1'b1;
    end else if (busy_reg) begin
      if (count_reg == 8'h00) begin
        busy_reg <= 1'b0;
      end else begin
        count_reg <= 8'(count_reg - 8'h01);
      end
    end
  end

  assign done_out = busy_reg && (count_reg == 8'h00);

endmodule // acr_pulse_timer

// ==== core/acr_regs.sv ====
// Channel configuration registers and conversion-ready pin control
`timescale 1ns/10ps

// Behaviour
// - Two-bit select picks ready source: lagging, OR, or leading enabled channel.
// - With nothing pending the pin is driven high, or floated when idle bit set.
// - Pending result shows as held low, or a fixed low pulse in pulse format.
// - Channel runs only while its enable bit (9 or 8) is set; both reset set.
// - Turbo bit 5 forces oversampling ratio 64 over the ratio field.
// - Ratio field bits 4:2 doubles from 128 to 16384; reset code selects 1024.
// - Power field picks very-low-power, low-power or high-resolution; resets high-res.
// - Channel 1 gain code bits 6:4 gives gain two to the power of code.
// - Channel 0 gain code bits 2:0 uses the same encoding, reset unity.
// - Clock register sits at address 3h and resets to 030Eh.
// - Gain register sits at address 4h and resets to 0000h.
// - Each channel has a new-data flag; ready sources derive from them.
// - Mode register holding the ready control fields sits at address 2h.
module acr_regs
  import acr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic [1:0]  conv_done_in,
  input  wire logic        result_read_in,
  output logic             conversion_ready_out,
  output logic             conversion_ready_oe_out,
  output logic      [1:0]  chan_enable_out,
  output logic      [14:0] oversample_ratio_out,
  output logic      [1:0]  power_level_out,
  output logic      [7:0]  chan0_gain_out,
  output logic      [7:0]  chan1_gain_out,
  output logic      [1:0]  new_data_flag_out,
  output logic             irq_out
);

  logic [3:0]     mode_reg;
  logic [15:0]    clock_reg;
  logic [15:0]    gain_reg;
  logic [15:0]    reserved_reg;
  logic [1:0]     irq_stat_reg;
  logic [1:0]     irq_mask_reg;
  logic [1:0]     irq_clear;
  logic [15:0]    rdata_reg;
  logic [15:0]    rdata_next;
  logic [1:0]     flag_reg;
  logic [1:0]     flag_next;
  logic [1:0]     flag_set;
  logic [1:0]     chan_en;
  logic [1:0]     flag_en;
  logic           lead_reg;
  logic           src;
  logic           pulse_start;
  logic           pulse_done;
  logic           pin_reg;
  logic           pin_oe_reg;
  logic           pin_next;
  logic           pin_oe_next;
  logic [14:0]    osr_reg;
  logic [14:0]    osr_next;
  logic [1:0]     pwr_reg;
  logic [7:0]     gain0_reg;
  logic [7:0]     gain_config_reg;
  logic           wr_mode;
  logic           wr_clock;
  logic           wr_gain;
  logic           wr_reserved;
  logic           wr_stat;
  logic           wr_mask;
  acr_rdy_state_t state_reg;
  acr_rdy_state_t state_next;

  // ==========================================================
  // Write decode
  // Writes to unmapped addresses match nothing and change nothing
  assign wr_mode     = reg_wr_in && (reg_addr_in == ACR_ADDR_MODE);
  assign wr_clock    = reg_wr_in && (reg_addr_in == ACR_ADDR_CLOCK);
  assign wr_gain     = reg_wr_in && (reg_addr_in == ACR_ADDR_GAIN);
  assign wr_reserved = reg_wr_in && (reg_addr_in == ACR_ADDR_RESERVED);
  assign wr_stat     = reg_wr_in && (reg_addr_in == ACR_ADDR_IRQ_STAT);
  assign wr_mask     = reg_wr_in && (reg_addr_in == ACR_ADDR_IRQ_MASK);

  // ==========================================================
  // Mode register tail: ready control fields only
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      mode_reg <= ACR_MODE_RST;
    end else if (wr_mode) begin
      mode_reg <= reg_wdata_in[3:0];
    end
  end

  // ==========================================================
  // Clock register; upper reserved bits stay zero
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      clock_reg <= ACR_CLOCK_RST;
    end else if (wr_clock) begin
      clock_reg <= reg_wdata_in & ACR_CLOCK_WMASK;
    end
  end

  // ==========================================================
  // Gain register
  // Reserved gain bits are kept as written; the host keeps them zero
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      gain_reg <= ACR_GAIN_RST;
    end else if (wr_gain) begin
      gain_reg <= reg_wdata_in;
    end
  end

  // ==========================================================
  // Reserved word: stored, no function
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      reserved_reg <= ACR_RESERVED_RST;
    end else if (wr_reserved) begin
      reserved_reg <= reg_wdata_in;
    end
  end

  // ==========================================================
  // Decoded configuration outputs
  assign chan_en = clock_reg[ACR_CLK_EN_LO +: 2];

  // Turbo overrides whatever the ratio field holds
  always_comb begin
    osr_next = 15'(ACR_OSR_BASE << clock_reg[ACR_CLK_OSR_LO +: 3]);
    if (clock_reg[ACR_CLK_TURBO]) begin
      osr_next = ACR_OSR_TURBO;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      osr_reg <= ACR_OSR_BASE;
    end else begin
      osr_reg <= osr_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pwr_reg <= ACR_CLOCK_RST[1:0];
    end else begin
      // Code 11 behaves as high resolution and is reported as 10
      unique case (clock_reg[ACR_CLK_PWR_LO +: 2])
        ACR_PWR_VLP: pwr_reg <= ACR_PWR_VLP;
        ACR_PWR_LP:  pwr_reg <= ACR_PWR_LP;
        default:     pwr_reg <= ACR_CLOCK_RST[1:0];
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      gain0_reg <= ACR_GAIN_UNIT;
      gain_config_reg <= ACR_GAIN_UNIT;
    end else begin
      gain0_reg <= 8'(ACR_GAIN_UNIT << gain_reg[ACR_GAIN0_LO +: 3]);
      gain_config_reg <= 8'(ACR_GAIN_UNIT << gain_reg[ACR_GAIN_CONFIG_LO +: 3]);
    end
  end

  // Enables come straight from the register; the decoded values are registered
  assign chan_enable_out      = chan_en;
  assign oversample_ratio_out = osr_reg;
  assign power_level_out      = pwr_reg;
  assign chan0_gain_out       = gain0_reg;
  assign chan1_gain_out       = gain_config_reg;

  // ==========================================================
  // Per-channel new-data flags; a set beats a same-cycle read
  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign flag_set[i]  = conv_done_in[i] && chan_en[i];
    assign flag_next[i] = (flag_reg[i] && !result_read_in) || flag_set[i];
    assign flag_en[i]   = flag_reg[i] && chan_en[i];
    assign irq_clear[i] = wr_stat && reg_wdata_in[i];

    always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
        flag_reg[i]     <= 1'b0;
        irq_stat_reg[i] <= ACR_IRQ_RST[i];
      end else begin
        flag_reg[i]     <= flag_next[i];
        // A new event beats a same-cycle write-one-to-clear
        irq_stat_reg[i] <= (irq_stat_reg[i] && !irq_clear[i]) || flag_set[i];
      end
    end
  end

  assign new_data_flag_out = flag_reg;

  // ==========================================================
  // Leading channel: first enabled channel to report after all clear
  // A tie goes to channel 0 so the choice is repeatable
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      lead_reg <= 1'b0;
    end else if (flag_en == 2'b00 && flag_set != 2'b00) begin
      lead_reg <= !flag_set[0];
    end
  end

  // ==========================================================
  // Ready source selection
  // Lagging waits for every enabled channel; OR takes any of them
  always_comb begin
    src = 1'b0;
    unique case (mode_reg[ACR_MODE_SEL_LO +: 2])
      ACR_SEL_LAG: src = (chan_en != 2'b00) && ((flag_en | ~chan_en) == 2'b11);
      ACR_SEL_OR:  src = |flag_en;
      default:     src = flag_en[lead_reg];
    endcase
  end

  // ==========================================================
  // Ready pin sequencer
  // Pulse format gives one pulse per rise of the source; SPENT waits for it to drop
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ACR_RDY_IDLE: begin
        if (src) begin
          state_next = mode_reg[ACR_MODE_FMT] ? ACR_RDY_PULSE : ACR_RDY_HOLD;
        end
      end
      ACR_RDY_HOLD: begin
        if (!src) begin
          state_next = ACR_RDY_IDLE;
        end else if (mode_reg[ACR_MODE_FMT]) begin
          state_next = ACR_RDY_SPENT;
        end
      end
      ACR_RDY_PULSE: begin
        if (pulse_done) begin
          state_next = src ? ACR_RDY_SPENT : ACR_RDY_IDLE;
        end
      end
      ACR_RDY_SPENT: begin
        if (!src) begin
          state_next = ACR_RDY_IDLE;
        end else if (!mode_reg[ACR_MODE_FMT]) begin
          state_next = ACR_RDY_HOLD;
        end
      end
      // Codes that are not one-hot fall back to idle
      default: state_next = ACR_RDY_IDLE;
    endcase
  end

  assign pulse_start = (state_reg != ACR_RDY_PULSE) && (state_next == ACR_RDY_PULSE);

  // Counts the low time of a pulse in whole clocks
  acr_pulse_timer u_pulse_timer (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .start_in (pulse_start),
    .done_out (pulse_done)
  );

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg <= ACR_RDY_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Pin drive, registered from the next state
  // Registering keeps the pin free of glitches between states
  always_comb begin
    pin_next    = 1'b1;
    pin_oe_next = !mode_reg[ACR_MODE_FLOAT];
    if (state_next == ACR_RDY_HOLD || state_next == ACR_RDY_PULSE) begin
      pin_next    = 1'b0;
      pin_oe_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pin_reg    <= 1'b1;
      pin_oe_reg <= 1'b1;
    end else begin
      pin_reg    <= pin_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign conversion_ready_out    = pin_reg;
  assign conversion_ready_oe_out = pin_oe_reg;

  // ==========================================================
  // Interrupt mask and output
  // A mask bit of one lets its status bit raise the interrupt
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      irq_mask_reg <= ACR_IRQ_RST;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata_in[1:0];
    end
  end

  assign irq_out = |(irq_stat_reg & irq_mask_reg);

  // ==========================================================
  // Read port: data in the cycle after the strobe only
  // Unmapped addresses and idle cycles read as zero
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ACR_ADDR_MODE:     rdata_next = {12'h000, mode_reg};
        ACR_ADDR_CLOCK:    rdata_next = clock_reg;
        ACR_ADDR_GAIN:     rdata_next = gain_reg;
        ACR_ADDR_RESERVED: rdata_next = reserved_reg;
        ACR_ADDR_IRQ_STAT: rdata_next = {14'h0000, irq_stat_reg};
        ACR_ADDR_IRQ_MASK: rdata_next = {14'h0000, irq_mask_reg};
        default:           rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

endmodule // acr_regs

// ==== verification/acr_regs_checker.sv ====
// Assertion checker for the converter configuration register bank
`timescale 1ns/10ps
module acr_regs_checker
  import acr_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [1:0]  conv_done_in,
  input wire logic        conversion_ready_out,
  input wire logic        conversion_ready_oe_out,
  input wire logic [1:0]  chan_enable_out,
  input wire logic [14:0] oversample_ratio_out,
  input wire logic [1:0]  power_level_out,
  input wire logic [7:0]  chan0_gain_out,
  input wire logic [7:0]  chan1_gain_out,
  input wire logic [1:0]  new_data_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire       clk_wr  = reg_wr_in && reg_addr_in == ACR_ADDR_CLOCK;
  wire       gain_wr = reg_wr_in && reg_addr_in == ACR_ADDR_GAIN;
  wire [1:0] set_ok  = conv_done_in & chan_enable_out;
  wire [1:0] set_no  = conv_done_in & ~chan_enable_out & ~new_data_flag_out;

  a_clock_readback: assert property (
    reg_rd_in && reg_addr_in == ACR_ADDR_CLOCK |=> reg_rdata_out[15:10] == 6'h00)
    else $error("clock register reserved bits read nonzero");
  a_chan_enable: assert property (
    clk_wr |=> chan_enable_out == $past(reg_wdata_in[9:8]))
    else $error("channel enables do not follow clock register");
  a_osr_map: assert property (
    clk_wr ##1 !clk_wr |=> oversample_ratio_out == ($past(reg_wdata_in[5], 2) ?
      ACR_OSR_TURBO : ACR_OSR_BASE << $past(reg_wdata_in[4:2], 2)))
    else $error("oversampling ratio wrong");
  a_power_map: assert property (
    clk_wr ##1 !clk_wr |=> power_level_out == ($past(reg_wdata_in[1:0], 2) == 2'h3 ?
      2'h2 : $past(reg_wdata_in[1:0], 2)))
    else $error("power level wrong");
  a_gain_map: assert property (
    gain_wr ##1 !gain_wr |=> chan0_gain_out == ACR_GAIN_UNIT << $past(reg_wdata_in[2:0], 2)
      && chan1_gain_out == ACR_GAIN_UNIT << $past(reg_wdata_in[6:4], 2))
    else $error("gain value wrong");
  a_pin_cause: assert property (
    $fell(conversion_ready_out) && conversion_ready_oe_out |-> $past(new_data_flag_out) != 2'h0)
    else $error("ready pin fell with no new data");
  a_flag_set: assert property (
    set_ok != 2'h0 |=> (new_data_flag_out & $past(set_ok)) == $past(set_ok))
    else $error("new data flag not set");
  a_flag_blocked: assert property (
    set_no != 2'h0 |=> (new_data_flag_out & $past(set_no)) == 2'h0)
    else $error("disabled channel set its flag");
endmodule // acr_regs_checker

bind acr_regs acr_regs_checker u_chk (
  .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .conv_done_in(conv_done_in),
  .conversion_ready_out(conversion_ready_out),
  .conversion_ready_oe_out(conversion_ready_oe_out), .chan_enable_out(chan_enable_out),
  .oversample_ratio_out(oversample_ratio_out), .power_level_out(power_level_out),
  .chan0_gain_out(chan0_gain_out), .chan1_gain_out(chan1_gain_out),
  .new_data_flag_out(new_data_flag_out));

// ==== verification/acr_host_model.sv ====
// Host side view of the conversion-ready pin
`timescale 1ns/10ps
module acr_host_model (
  input  wire logic clk_in,
  input  wire logic pin_in,
  input  wire logic oe_in,
  output logic      pin_wire_out
);
  logic toggle_reg = 1'b0;
  always_ff @(posedge clk_in) begin
    toggle_reg <= ~toggle_reg;
  end
  // A released pin shows a changing level so a stale value never passes
  assign pin_wire_out = oe_in ? pin_in : toggle_reg;
endmodule // acr_host_model

// ==== verification/tb.sv ====
// Self-checking bench for the converter configuration register bank
`timescale 1ns/10ps
module tb;
  import acr_pkg::*;
  logic clk_in = 1'b0, nrst_in = 1'b0, wr = 1'b0, rd = 1'b0, rr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [1:0] done = 2'h0, en, power_level, flag;
  logic [14:0] oversample_ratio;
  logic [7:0] g0, g1;
  logic pin, oe, irq, pin_w;
  int m_mode = 0, m_clk = 'h30e, m_gain = 0, m_res = 0, m_stat = 0, m_mask = 0;
  int m_flag = 0, lead = 0, seed = 56526, err_count = 0, cmp_count = 0, n;

  always #20 clk_in = ~clk_in;
  acr_regs u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .conv_done_in(done), .result_read_in(rr), .conversion_ready_out(pin),
    .conversion_ready_oe_out(oe), .chan_enable_out(en), .oversample_ratio_out(oversample_ratio),
    .power_level_out(power_level), .chan0_gain_out(g0), .chan1_gain_out(g1),
    .new_data_flag_out(flag), .irq_out(irq));
  acr_host_model u_host (.clk_in(clk_in), .pin_in(pin), .oe_in(oe), .pin_wire_out(pin_w));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic int exp_rd(input int a);
    case (a)
      2: return m_mode & 15;
      3: return m_clk;
      4: return m_gain;
      5: return m_res;
      8: return m_stat;
      9: return m_mask;
      default: return 0;
    endcase
  endfunction
  function automatic bit src();
    int e;
    e = (m_clk >> 8) & 3;
    case ((m_mode >> 2) & 3)
      0: return e != 0 && (m_flag & e) == e;
      1: return (m_flag & e) != 0;
      default: return (m_flag >> lead) & 1;
    endcase
  endfunction
  task automatic wr_reg(input int a, input int d);
    @(posedge clk_in);
    addr <= 4'(a);
    wdata <= 16'(d);
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    case (a)
      2: m_mode = d & 15;
      3: m_clk = d & 'h3ff;
      4: m_gain = d;
      5: m_res = d;
      8: m_stat = m_stat & ~d;
      9: m_mask = d & 3;
      default: ;
    endcase
  endtask
  task automatic rd_reg(input int a);
    @(posedge clk_in);
    addr <= 4'(a);
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    chk(rdata, 16'(exp_rd(a)));
  endtask
  task automatic outs();
    @(posedge clk_in);
    @(negedge clk_in);
    chk(16'(en), 16'((m_clk >> 8) & 3));
    chk(16'(oversample_ratio), 16'((m_clk & 32) != 0 ? 64 : 128 << ((m_clk >> 2) & 7)));
    chk(16'(power_level), 16'((m_clk & 3) == 3 ? 2 : m_clk & 3));
    chk(16'(g0), 16'(1 << (m_gain & 7)));
    chk(16'(g1), 16'(1 << ((m_gain >> 4) & 7)));
  endtask
  task automatic ev(input int d, input bit r);
    int nf;
    @(posedge clk_in);
    done <= 2'(d);
    rr <= r;
    @(posedge clk_in);
    done <= 2'h0;
    rr <= 1'b0;
    nf = d & (m_clk >> 8) & 3;
    if (m_flag == 0 && nf != 0) lead = (nf & 1) ? 0 : 1;
    m_flag = r ? nf : m_flag | nf;
    m_stat = m_stat | nf;
    @(posedge clk_in);
    @(negedge clk_in);
    chk(16'(flag), 16'(m_flag));
    chk(16'(irq), 16'((m_stat & m_mask) != 0));
    if (!m_mode[0]) begin
      chk(16'(oe), 16'(src() || !m_mode[1]));
      if (src() || !m_mode[1]) chk(16'(pin_w), 16'(!src()));
    end
  endtask

  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 16; i++) rd_reg(i);
    outs();
    for (int i = 0; i < 32; i++) begin
      wr_reg(3, ($random(seed) & 'h320) | i);
      wr_reg(4, $random(seed) & 'h77);
      outs();
      rd_reg(3);
      rd_reg(4);
    end
    wr_reg(3, 'h30e);
    wr_reg(5, 0);
    rd_reg(5);
    wr_reg(9, 3);
    for (int i = 0; i < 4; i++) begin
      wr_reg(2, i << 2);
      ev(1, 0);
      ev(2, 0);
      rd_reg(8);
      wr_reg(8, 3);
      ev(0, 1);
    end
    wr_reg(9, 0);
    ev(1, 0);
    ev(0, 1);
    wr_reg(3, 'h10e);
    wr_reg(2, 0);
    ev(2, 0);
    ev(1, 0);
    ev(0, 1);
    wr_reg(3, 'h30e);
    wr_reg(2, 2);
    ev(0, 0);
    ev(1, 0);
    ev(0, 1);
    wr_reg(2, 5);
    ev(1, 0);
    n = (pin_w === 1'b0);
    repeat (20) begin
      @(negedge clk_in);
      if (pin_w === 1'b0) n++;
    end
    chk(16'(n), 16'(ACR_PULSE_CYCLES));
    ev(0, 1);
    stop_test();
  end
endmodule // tb
